// ==== crfc_core.sv ====
// CPU register file core: registers, data space, fetch, stack, interrupts, sleep
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - 32 x 8 register file gives two operands and takes the result each cycle.
// - Six registers double as three 16-bit pointers X, Y, Z.
// - The Z pointer also addresses constant table reads from program memory.
// - Registers sit at the lowest 32 data-space addresses.
// - 64 I/O locations, reached directly or right after the registers.
// - Two-stage pipeline prefetches the next word while one executes.
// - Program words are 16 bits; some instructions take two words.
// - Relative jumps and calls reach the whole program space.
// - Calls and interrupts push the return counter onto the SRAM stack.
// - Stack pointer is 10 bits, read and written through I/O space.
// - Data SRAM is reached through five addressing modes.
// - Global enable in the status register gates interrupt acceptance.
// - Each source has its own vector; the lower vector wins.
// - Idle sleep halts the CPU; interrupts and peripherals keep running.
// - Power-down stops the main oscillator until an interrupt or reset.
// - Power-save keeps the timer oscillator running.
// - Low reset input resets the device; pulses over 50 ns count.
// - During reset all port pins float, even without a clock.
module crfc_core (
   input  wire logic                                    clock_i,
   input  wire logic                                    rstn_i,
   input  wire logic [15:0]                             bus_addr_i,
   input  wire logic [7:0]                              bus_wdata_i,
   input  wire logic                                    bus_we_i,
   input  wire logic                                    bus_re_i,
   output logic      [7:0]                              bus_rdata_o,
   input  wire crfc_pkg::crfc_alu_req_t                 alu_i,
   output logic      [7:0]                              alu_opd_o,
   output logic      [7:0]                              alu_opr_o,
   input  wire crfc_pkg::crfc_mem_req_t                 mem_i,
   output logic      [7:0]                              mem_rdata_o,
   input  wire crfc_pkg::crfc_flow_t                    flow_i,
   output logic      [crfc_pkg::PC_W-1:0]               pm_addr_o,
   input  wire logic [15:0]                             pm_data_i,
   output logic      [15:0]                             instr_o,
   output logic                                         instr_valid_o,
   output crfc_pkg::crfc_ptrs_t                         ptrs_o,
   output logic      [15:0]                             table_addr_o,
   input  wire logic [crfc_pkg::NUM_IRQ-1:0]            irq_i,
   output logic      [crfc_pkg::NUM_IRQ-1:0]            irq_ack_o,
   output logic                                         cpu_halt_o,
   output logic                                         main_osc_run_o,
   output logic                                         timer_osc_run_o,
   input  wire logic [crfc_pkg::NUM_PORT-1:0][7:0]      pins_i,
   output logic      [crfc_pkg::NUM_PORT-1:0][7:0]      port_out_o,
   output logic      [crfc_pkg::NUM_PORT-1:0][7:0]      port_oe_o
);
   import crfc_pkg::*;

   // ==========================================================
   // Data-space access helpers
   function automatic logic [7:0] ds_rd(input crfc_state_t s, input logic [15:0] a);
      logic [7:0]  v;
      logic [15:0] o;
      v = '0;
      o = a - SRAM_BASE;
      if (a < IO_BASE) begin
         v = s.gpr[a[4:0]];
      end else if (a < SRAM_BASE) begin
         o = a - IO_BASE;
         v = s.io[o[5:0]];
         for (int p = 0; p < NUM_PORT; p++) begin
            if (o[5:0] == PORT_PIN_IDX[p]) v = s.pin_val[p];
         end
      end else if (a <= SRAM_END) begin
         v = s.sram[o[8:0]];
      end
      return v;
   endfunction : ds_rd

   function automatic crfc_state_t ds_wr(input crfc_state_t s, input logic [15:0] a,
                                         input logic [7:0] d);
      logic [15:0] o;
      o = a - SRAM_BASE;
      if (a < IO_BASE) begin
         s.gpr[a[4:0]] = d;
      end else if (a < SRAM_BASE) begin
         o = a - IO_BASE;
         s.io[o[5:0]] = d;
      end else if (a <= SRAM_END) begin
         s.sram[o[8:0]] = d;
      end
      return s;
   endfunction : ds_wr

   function automatic logic [SP_W-1:0] sp_of(input crfc_state_t s);
      return {s.io[IO_SPH][SP_W-9:0], s.io[IO_SPL]};
   endfunction : sp_of

   function automatic crfc_state_t set_sp(input crfc_state_t s, input logic [SP_W-1:0] sp);
      s.io[IO_SPH] = 8'(sp[SP_W-1:8]);
      s.io[IO_SPL] = sp[7:0];
      return s;
   endfunction : set_sp

   // Low byte at SP, high byte below it, post-decrement by two
   function automatic crfc_state_t push_pc(input crfc_state_t s, input logic [PC_W-1:0] pc);
      logic [SP_W-1:0] sp;
      logic [15:0]     ret;
      sp  = sp_of(s);
      ret = 16'(pc);
      s   = ds_wr(s, 16'(sp), ret[7:0]);
      s   = ds_wr(s, 16'(sp - SP_ONE), ret[15:8]);
      s   = set_sp(s, sp - SP_TWO);
      return s;
   endfunction : push_pc

   function automatic crfc_state_t pop_pc(input crfc_state_t s);
      logic [SP_W-1:0] sp;
      logic [15:0]     ret;
      sp   = sp_of(s);
      ret  = {ds_rd(s, 16'(sp + SP_ONE)), ds_rd(s, 16'(sp + SP_TWO))};
      s.pc = ret[PC_W-1:0];
      s    = set_sp(s, sp + SP_TWO);
      return s;
   endfunction : pop_pc

   // ==========================================================
   // State and combinational terms
   crfc_state_t          s_q;
   crfc_state_t          s_d;
   logic [NUM_IRQ-1:0]   pend;
   logic [IRQ_IDX_W-1:0] vec;
   logic                 gie;
   logic                 irq_take;
   logic                 exec;
   logic                 sleep_en;
   logic [1:0]           sleep_mode;
   logic [4:0]           plo;
   logic [15:0]          ptr;
   logic [15:0]          eff_addr;
   logic [15:0]          ptr_new;
   logic                 ptr_upd;
   logic [SP_W-1:0]      sp_now;

   assign gie        = s_q.io[IO_SREG][GIE_BIT];
   assign pend       = irq_i & s_q.io[IO_IRQ_MASK];
   // Taken only on a valid instruction boundary, so the pushed address is real
   assign irq_take   = gie && (|pend) && (s_q.run == ST_RUN) && s_q.instr_valid;
   assign exec       = (s_q.run == ST_RUN) && s_q.instr_valid && !irq_take;
   assign sleep_en   = s_q.io[IO_SLEEP_CTL][SLEEP_EN_BIT];
   assign sleep_mode = s_q.io[IO_SLEEP_CTL][SLEEP_MODE_LSB +: 2];
   assign sp_now     = sp_of(s_q);
   assign irq_ack_o  = irq_take ? (pend & (-pend)) : '0;

   always_comb begin
      vec = '0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (pend[i]) vec = IRQ_IDX_W'(i);
      end
   end

   // ==========================================================
   // Effective address for the data-memory port
   always_comb begin
      unique case (mem_i.ptr_sel)
         PTR_X:   plo = X_LO;
         PTR_Y:   plo = Y_LO;
         PTR_Z:   plo = Z_LO;
         default: plo = Z_LO;
      endcase
      ptr      = {s_q.gpr[plo + GPR_PAIR_STEP], s_q.gpr[plo]};
      eff_addr = mem_i.direct;
      ptr_new  = ptr;
      ptr_upd  = 1'b0;
      unique case (mem_i.mode)
         AM_DIRECT:  eff_addr = mem_i.direct;
         AM_IO:      eff_addr = IO_BASE + 16'(mem_i.direct[5:0]);
         AM_IND:     eff_addr = ptr;
         AM_POSTINC: begin
            eff_addr = ptr;
            ptr_new  = ptr + PTR_ONE;
            ptr_upd  = 1'b1;
         end
         AM_PREDEC:  begin
            eff_addr = ptr - PTR_ONE;
            ptr_new  = ptr - PTR_ONE;
            ptr_upd  = 1'b1;
         end
         AM_DISP:    eff_addr = ptr + 16'(mem_i.disp);
         default:    eff_addr = mem_i.direct;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      // Pin sampling: a bit moves only when the last two stages agree
      s_d.pin_s1  = pins_i;
      s_d.pin_s2  = s_q.pin_s1;
      s_d.pin_s3  = s_q.pin_s2;
      s_d.pin_val = (s_q.pin_val & (s_q.pin_s2 ^ s_q.pin_s3))
                  | (s_q.pin_s3 & ~(s_q.pin_s2 ^ s_q.pin_s3));

      s_d.bus_rdata = bus_re_i ? ds_rd(s_q, bus_addr_i) : '0;
      if (bus_we_i) s_d = ds_wr(s_d, bus_addr_i, bus_wdata_i);

      s_d.mem_rdata = '0;
      if (exec && mem_i.req) begin
         if (mem_i.we) s_d = ds_wr(s_d, eff_addr, mem_i.wdata);
         else          s_d.mem_rdata = ds_rd(s_q, eff_addr);
         if (ptr_upd) begin
            s_d.gpr[plo]                 = ptr_new[7:0];
            s_d.gpr[plo + GPR_PAIR_STEP] = ptr_new[15:8];
         end
      end

      // Same-cycle writeback of the arithmetic result
      if (exec && alu_i.we) s_d.gpr[alu_i.rd_sel] = alu_i.res;

      unique case (s_q.run)
         ST_RUN: begin
            if (irq_take) begin
               s_d = push_pc(s_d, s_q.ex_pc);
               s_d.pc = IRQ_VEC_BASE + PC_W'(vec);
               s_d.instr_valid = 1'b0;
               s_d.io[IO_SREG][GIE_BIT] = 1'b0;
            end else if (exec && (flow_i.rjmp || flow_i.call)) begin
               if (flow_i.call) s_d = push_pc(s_d, s_q.ex_pc + PC_ONE);
               // Modulo arithmetic makes every word reachable
               s_d.pc = s_q.ex_pc + PC_ONE + flow_i.offset;
               s_d.instr_valid = 1'b0;
            end else if (exec && flow_i.ret) begin
               s_d = pop_pc(s_d);
               s_d.instr_valid = 1'b0;
               if (flow_i.reti) s_d.io[IO_SREG][GIE_BIT] = 1'b1;
            end else if (exec && flow_i.sleep && sleep_en) begin
               s_d.instr_valid = 1'b0;
               if (sleep_mode == SLP_PDOWN)      s_d.run = ST_PDOWN;
               else if (sleep_mode == SLP_PSAVE) s_d.run = ST_PSAVE;
               else                              s_d.run = ST_IDLE;
            end else begin
               s_d.instr = pm_data_i;
               s_d.ex_pc = s_q.pc;
               s_d.pc    = s_q.pc + PC_ONE;
               // Second word of a long instruction is operand, not opcode
               s_d.instr_valid = !(exec && flow_i.two_word);
            end
         end
         ST_IDLE, ST_PDOWN, ST_PSAVE: begin
            if (|pend) s_d.run = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   assign bus_rdata_o     = s_q.bus_rdata;
   assign mem_rdata_o     = s_q.mem_rdata;
   assign alu_opd_o       = s_q.gpr[alu_i.rd_sel];
   assign alu_opr_o       = s_q.gpr[alu_i.rr_sel];
   assign pm_addr_o       = s_q.pc;
   assign instr_o         = s_q.instr;
   assign instr_valid_o   = s_q.instr_valid;
   assign ptrs_o.x        = {s_q.gpr[X_LO + GPR_PAIR_STEP], s_q.gpr[X_LO]};
   assign ptrs_o.y        = {s_q.gpr[Y_LO + GPR_PAIR_STEP], s_q.gpr[Y_LO]};
   assign ptrs_o.z        = {s_q.gpr[Z_LO + GPR_PAIR_STEP], s_q.gpr[Z_LO]};
   assign table_addr_o    = ptrs_o.z;
   assign cpu_halt_o      = (s_q.run != ST_RUN);
   assign main_osc_run_o  = (s_q.run == ST_RUN) || (s_q.run == ST_IDLE);
   assign timer_osc_run_o = (s_q.run != ST_PDOWN);

   // Reset gates enables straight from the pin: no clock needed to float
   always_comb begin
      for (int p = 0; p < NUM_PORT; p++) begin
         port_out_o[p] = s_q.io[PORT_OUT_IDX[p]];
         port_oe_o[p]  = rstn_i ? s_q.io[PORT_DIR_IDX[p]] : '0;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   AST_ALU_WRITEBACK: assert property (
      exec && alu_i.we && !bus_we_i && !mem_i.req ##1 alu_i.rd_sel == $past(alu_i.rd_sel)
      |-> alu_opd_o == $past(alu_i.res))
      else $error("ALU result not written back");

   AST_PTR_POSTINC: assert property (
      exec && mem_i.req && !mem_i.we && mem_i.mode == AM_POSTINC && mem_i.ptr_sel == PTR_Z
      && !alu_i.we && !bus_we_i |=> ptrs_o.z == $past(ptrs_o.z) + PTR_ONE)
      else $error("Z pointer did not post-increment");

   AST_TABLE_ADDR: assert property (
      bus_we_i && bus_addr_i == 16'(Z_LO) && !(exec && (alu_i.we || mem_i.req))
      |=> table_addr_o[7:0] == $past(bus_wdata_i))
      else $error("Table address does not follow Z low byte");

   AST_GPR_IN_DATA_SPACE: assert property (
      bus_we_i && bus_addr_i < IO_BASE && !(exec && (alu_i.we || mem_i.req))
      ##1 bus_re_i && bus_addr_i == $past(bus_addr_i) |=> bus_rdata_o == $past(bus_wdata_i, 2))
      else $error("Register not readable as data space");

   AST_IO_DIRECT: assert property (
      exec && mem_i.req && mem_i.we && mem_i.mode == AM_IO && !flow_i.call
      && mem_i.direct[5:0] == PORT_OUT_IDX[0] |=> port_out_o[0] == $past(mem_i.wdata))
      else $error("Direct I/O write lost");

   AST_PREFETCH: assert property (
      // Reset edge excluded: the register is still cleared there
      rstn_i && s_q.run == ST_RUN && !irq_take
      && !(exec && (flow_i.rjmp || flow_i.call || flow_i.ret || flow_i.sleep))
      |=> pm_addr_o == $past(pm_addr_o) + PC_ONE && instr_o == $past(pm_data_i))
      else $error("Prefetch did not advance");

   AST_REL_JUMP: assert property (
      exec && flow_i.rjmp
      |=> pm_addr_o == $past(s_q.ex_pc) + PC_ONE + $past(flow_i.offset) && !instr_valid_o)
      else $error("Relative jump target wrong");

   AST_CALL_PUSH: assert property (
      exec && flow_i.call && !bus_we_i && !(mem_i.req && mem_i.we)
      |=> sp_now == $past(sp_now) - SP_TWO)
      else $error("Call did not push two bytes");

   AST_GIE_GATE: assert property (
      !gie |-> irq_ack_o == '0)
      else $error("Interrupt taken while globally disabled");

   AST_PRIORITY: assert property (
      irq_take |-> ((irq_ack_o - 1'b1) & pend) == '0 && (irq_ack_o & pend) != '0
      ##1 pm_addr_o == IRQ_VEC_BASE + PC_W'($past(vec)))
      else $error("Lower vector did not win");

   AST_POWER_DOWN: assert property (
      exec && flow_i.sleep && sleep_en && sleep_mode == SLP_PDOWN
      && !flow_i.rjmp && !flow_i.call && !flow_i.ret
      |=> cpu_halt_o && !main_osc_run_o && !timer_osc_run_o)
      else $error("Power-down left an oscillator running");

   AST_WAKE: assert property (
      cpu_halt_o && (|pend) |=> !cpu_halt_o && $stable(pm_addr_o))
      else $error("Sleep did not end on interrupt");

   COV_CALL:  cover property (exec && flow_i.call ##1 !instr_valid_o);
   COV_IRQ:   cover property (irq_take ##1 !instr_valid_o);
   COV_SLEEP: cover property (s_q.run == ST_PSAVE ##[1:20] !cpu_halt_o);

endmodule : crfc_core

`default_nettype wire

// ==== crfc_pkg.sv ====
// Constants and carrier types for the CPU register file core
package crfc_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned NUM_GPR   = 32;
   localparam int unsigned IO_SIZE   = 64;
   localparam int unsigned SRAM_SIZE = 512;
   localparam int unsigned NUM_IRQ   = 8;
   localparam int unsigned IRQ_IDX_W = 3;
   localparam int unsigned NUM_PORT  = 4;
   localparam int unsigned PC_W      = 12;
   localparam int unsigned SP_W      = 10;

   // ==========================================================
   // Data space map
   localparam logic [15:0] IO_BASE   = 16'h0020;
   localparam logic [15:0] SRAM_BASE = 16'h0060;
   localparam logic [15:0] SRAM_END  = 16'h025F;

   // ==========================================================
   // Pointer pairs (low byte index)
   localparam logic [4:0]  X_LO          = 5'h1A;
   localparam logic [4:0]  Y_LO          = 5'h1C;
   localparam logic [4:0]  Z_LO          = 5'h1E;
   localparam logic [4:0]  GPR_PAIR_STEP = 5'h01;

   // ==========================================================
   // I/O locations (index within I/O space)
   localparam logic [5:0] IO_SREG      = 6'h3F;
   localparam logic [5:0] IO_SPH       = 6'h3E;
   localparam logic [5:0] IO_SPL       = 6'h3D;
   localparam logic [5:0] IO_IRQ_MASK  = 6'h3B;
   localparam logic [5:0] IO_SLEEP_CTL = 6'h35;
   localparam logic [NUM_PORT-1:0][5:0] PORT_OUT_IDX = {6'h12, 6'h15, 6'h18, 6'h1B};
   localparam logic [NUM_PORT-1:0][5:0] PORT_DIR_IDX = {6'h11, 6'h14, 6'h17, 6'h1A};
   localparam logic [NUM_PORT-1:0][5:0] PORT_PIN_IDX = {6'h10, 6'h13, 6'h16, 6'h19};

   // ==========================================================
   // Fields
   localparam int unsigned GIE_BIT        = 7;
   localparam int unsigned SLEEP_EN_BIT   = 6;
   localparam int unsigned SLEEP_MODE_LSB = 4;
   localparam logic [1:0]  SLP_IDLE       = 2'h0;
   localparam logic [1:0]  SLP_PDOWN      = 2'h2;
   localparam logic [1:0]  SLP_PSAVE      = 2'h3;

   // ==========================================================
   // Vectors, steps, timing
   localparam logic [PC_W-1:0] RESET_VEC    = 12'h000;
   localparam logic [PC_W-1:0] IRQ_VEC_BASE = 12'h001;
   localparam logic [PC_W-1:0] PC_ONE       = 12'h001;
   localparam logic [15:0]     PTR_ONE      = 16'h0001;
   localparam logic [SP_W-1:0] SP_ONE       = 10'h001;
   localparam logic [SP_W-1:0] SP_TWO       = 10'h002;
   localparam int unsigned RST_MIN_NS    = 50;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {AM_DIRECT, AM_IO, AM_IND, AM_POSTINC, AM_PREDEC, AM_DISP}
      crfc_amode_t;
   typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} crfc_ptr_sel_t;
   typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PDOWN, ST_PSAVE} crfc_run_t;

   typedef struct packed {
      logic          req;
      logic          we;
      crfc_amode_t   mode;
      crfc_ptr_sel_t ptr_sel;
      logic [5:0]    disp;
      logic [15:0]   direct;
      logic [7:0]    wdata;
   } crfc_mem_req_t;

   typedef struct packed {
      logic [4:0] rd_sel;
      logic [4:0] rr_sel;
      logic       we;
      logic [7:0] res;
   } crfc_alu_req_t;

   typedef struct packed {
      logic            rjmp;
      logic            call;
      logic            ret;
      logic            reti;
      logic            two_word;
      logic            sleep;
      logic [PC_W-1:0] offset;
   } crfc_flow_t;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } crfc_ptrs_t;

   typedef struct packed {
      logic [NUM_GPR-1:0][7:0]   gpr;
      logic [IO_SIZE-1:0][7:0]   io;
      logic [SRAM_SIZE-1:0][7:0] sram;
      logic [PC_W-1:0]           pc;
      logic [PC_W-1:0]           ex_pc;
      logic [15:0]               instr;
      logic                      instr_valid;
      crfc_run_t                 run;
      logic [7:0]                bus_rdata;
      logic [7:0]                mem_rdata;
      logic [NUM_PORT-1:0][7:0]  pin_s1;
      logic [NUM_PORT-1:0][7:0]  pin_s2;
      logic [NUM_PORT-1:0][7:0]  pin_s3;
      logic [NUM_PORT-1:0][7:0]  pin_val;
   } crfc_state_t;

endpackage : crfc_pkg

// ==== crfc_far_model.sv ====
// Far-side model: program memory and port pins with pull-ups
`timescale 1ns/1ps
`default_nettype none
module crfc_far_model (
   input  wire logic [crfc_pkg::PC_W-1:0]          pm_addr_i,
   output logic      [15:0]                        pm_data_o,
   input  wire logic [crfc_pkg::NUM_PORT-1:0][7:0] port_out_i,
   input  wire logic [crfc_pkg::NUM_PORT-1:0][7:0] port_oe_i,
   output logic      [crfc_pkg::NUM_PORT-1:0][7:0] pins_o
);
   import crfc_pkg::*;
   // ==========================================================
   // Arbitrary word pattern; the bench plays the decoder
   assign pm_data_o = {4'hC, pm_addr_i};
   // Released pins are pulled high, never left at the last value
   assign pins_o = (port_out_i & port_oe_i) | ~port_oe_i;
endmodule : crfc_far_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the CPU register file core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import crfc_pkg::*;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [15:0] addr = '0;
   logic [7:0] wdata = '0;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [7:0] rdata, opd, opr, mrd;
   crfc_alu_req_t alu = '0;
   crfc_mem_req_t mem = '0;
   crfc_flow_t flow = '0;
   logic [PC_W-1:0] pma;
   logic [15:0] pmd, instr, taddr;
   logic vld, halt, mosc, tosc;
   crfc_ptrs_t ptrs;
   logic [NUM_IRQ-1:0] irq = '0;
   logic [NUM_IRQ-1:0] ack;
   logic [NUM_PORT-1:0][7:0] pins, pout, poe;
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   logic [7:0] v;
   logic [PC_W-1:0] pa;

   always #25 clock_i = ~clock_i;

   crfc_core u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .bus_addr_i(addr),
      .bus_wdata_i(wdata), .bus_we_i(we), .bus_re_i(re), .bus_rdata_o(rdata),
      .alu_i(alu), .alu_opd_o(opd), .alu_opr_o(opr), .mem_i(mem), .mem_rdata_o(mrd),
      .flow_i(flow), .pm_addr_o(pma), .pm_data_i(pmd), .instr_o(instr),
      .instr_valid_o(vld), .ptrs_o(ptrs), .table_addr_o(taddr), .irq_i(irq),
      .irq_ack_o(ack), .cpu_halt_o(halt), .main_osc_run_o(mosc),
      .timer_osc_run_o(tosc), .pins_i(pins), .port_out_o(pout), .port_oe_o(poe));
   crfc_far_model u_far (.pm_addr_i(pma), .pm_data_o(pmd), .port_out_i(pout),
      .port_oe_i(poe), .pins_o(pins));

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, m, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      we <= 1'b1; addr <= a; wdata <= d;
      @(posedge clock_i);
      we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock_i);
      re <= 1'b1; addr <= a;
      @(posedge clock_i);
      re <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // Write then read with no idle cycle between the strobes
   task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clock_i);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock_i);
      we <= 1'b0;
      re <= 1'b1;
      @(posedge clock_i);
      re <= 1'b0;
      #1 q = rdata;
   endtask : wr_rd

   // One executed instruction; pa is the prefetch address seen meanwhile
   task automatic ex(input crfc_alu_req_t a, input crfc_mem_req_t m,
                     input crfc_flow_t f, output logic [PC_W-1:0] p);
      int n;
      n = 0;
      while (vld !== 1'b1 && n < 20) begin
         @(negedge clock_i);
         n++;
      end
      @(posedge clock_i);
      alu <= a; mem <= m; flow <= f;
      #1 p = pma;
      @(posedge clock_i);
      alu <= '0; mem <= '0; flow <= '0;
      #1;
   endtask : ex

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // ==========================================================
   // Scenarios
   task automatic t_space();
      wr(16'h0060, 8'h11); wr(16'h025F, 8'h22);
      rd(16'h0060, v); chk(v, 8'h11, "sram low");
      rd(16'h025F, v); chk(v, 8'h22, "sram top");
      rd(16'h0300, v); chk(v, 8'h00, "unmapped");
      wr(16'h005E, 8'h02); wr(16'h005D, 8'h5F);
      rd(16'h005E, v); chk(v, 8'h02, "stack high via io");
      wr(16'h001E, 8'h60); wr(16'h001F, 8'h00);
      wr_rd(16'h0003, 8'hA5, v); chk(v, 8'hA5, "reg as memory");
      chk(taddr, 16'h0060, "table addr");
   endtask : t_space

   task automatic t_exec();
      crfc_alu_req_t a;
      crfc_mem_req_t m;
      a = '{rd_sel:5'd0, rr_sel:5'h1E, we:1'b1, res:8'h3C};
      m = '{req:1'b1, we:1'b0, mode:AM_POSTINC, ptr_sel:PTR_Z, disp:6'h00,
            direct:16'h0000, wdata:8'h00};
      ex(a, '0, '0, pa);
      chk(opd, 8'h3C, "result written back");
      ex('0, m, '0, pa);
      chk(mrd, 8'h11, "post-inc read");
      chk(ptrs.z, 16'h0061, "z incremented");
      a.we = 1'b0;
      @(posedge clock_i);
      alu <= a;
      #1 chk(opr, 8'h61, "operand r");
      chk(opd, 8'h3C, "operand d");
   endtask : t_exec

   task automatic t_jump();
      crfc_flow_t f;
      f = '0;
      f.rjmp = 1'b1;
      f.offset = 12'hFFE;
      ex('0, '0, f, pa);
      chk(pma, PC_W'(pa + 12'hFFE), "backward jump");
      chk(vld, 1'b0, "bubble after jump");
      @(posedge clock_i);
      #1 chk(instr, {4'hC, PC_W'(pa + 12'hFFE)}, "target fetched");
   endtask : t_jump

   // Call pushes the return word, return with reti pops it and enables
   task automatic t_call();
      crfc_flow_t f;
      logic [PC_W-1:0] r;
      f = '0;
      f.call = 1'b1;
      f.offset = 12'h010;
      ex('0, '0, f, pa);
      chk(pma, PC_W'(pa + 12'h010), "call target");
      rd(16'h005D, v); chk(v, 8'h5D, "two bytes pushed");
      rd(16'h025F, v); chk(v, pa[7:0], "return low byte");
      f = '0;
      f.ret = 1'b1;
      f.reti = 1'b1;
      ex('0, '0, f, r);
      chk(pma, pa, "returned");
      rd(16'h005F, v); chk(v, 8'h80, "reti enables");
   endtask : t_call

   task automatic t_irq();
      int n;
      wr(16'h005B, 8'h06); wr(16'h005F, 8'h80);
      @(posedge clock_i);
      irq <= 8'h06;
      n = 0;
      while (ack === 8'h00 && n < 20) begin
         @(negedge clock_i);
         n++;
      end
      chk(ack, 8'h02, "lowest vector wins");
      @(posedge clock_i);
      irq <= 8'h00;
      #1 chk(pma, 12'h002, "vector address");
      rd(16'h005D, v); chk(v, 8'h5D, "return pushed");
      rd(16'h005F, v); chk(v, 8'h00, "global enable off");
   endtask : t_irq

   task automatic t_sleep();
      crfc_flow_t f;
      logic [1:0] md [3];
      md = '{SLP_IDLE, SLP_PDOWN, SLP_PSAVE};
      f = '0;
      f.sleep = 1'b1;
      foreach (md[i]) begin
         wr(16'h0055, 8'h40 | {2'h0, md[i], 4'h0});
         ex('0, '0, f, pa);
         chk(halt, 1'b1, "halted");
         chk(mosc, md[i] == SLP_IDLE, "main osc");
         chk(tosc, md[i] != SLP_PDOWN, "timer osc");
         @(posedge clock_i);
         irq <= 8'h02;
         repeat (2) @(posedge clock_i);
         // Request still high with a valid opcode: only the global enable blocks it
         #1 chk(halt, 1'b0, "woken");
         chk(ack, 8'h00, "no accept while disabled");
         @(posedge clock_i);
         irq <= 8'h00;
      end
   endtask : t_sleep

   task automatic t_pins();
      crfc_mem_req_t m;
      m = '{req:1'b1, we:1'b1, mode:AM_IO, ptr_sel:PTR_X, disp:6'h00,
            direct:16'h001B, wdata:8'h3C};
      ex('0, m, '0, pa);
      chk(pout[0], 8'h3C, "direct io write");
      wr(16'h003A, 8'h0F);
      repeat (6) @(posedge clock_i);
      rd(16'h0039, v); chk(v, 8'hFC, "pin read via io");
      @(posedge clock_i);
      rstn_i <= 1'b0;
      #5 chk(poe[0], 8'h00, "float at once");
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      rd(16'h005D, v); chk(v, 8'h00, "stack cleared by reset");
   endtask : t_pins

   // ==========================================================
   // Main sequence and hang guard
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         print_verdict();
      end
   end

   initial begin
      #5 chk(poe, '0, "float in reset");
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      t_space();
      t_exec();
      t_jump();
      t_call();
      t_irq();
      t_sleep();
      t_pins();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
